// ### core/pwe_channel.sv
`timescale 1ns/1ps
`default_nettype none
module pwe_channel
    import pwe_pkg::*;
(
    // Clock and reset
    input  wire logic          mclk,
    input  wire logic          rst_n,
    // Control
    input  wire logic          tick,
    input  wire logic          start,
    input  wire logic          stop_req,
    input  wire logic          center,
    input  wire logic [CW-1:0] period_ld,
    input  wire logic [CW-1:0] duty,
    input  wire logic          upd_we,
    input  wire logic [CW-1:0] upd_val,
    // State
    output logic               running,
    output logic               period_end,
    output logic               wave
);

    logic          running_reg;
    logic          down_reg;
    logic          stop_pend_reg;
    logic          upd_pend_reg;
    logic [CW-1:0] upd_val_reg;
    logic [CW-1:0] period_reg;
    logic [CW-1:0] count_reg;
    logic          end_reg;
    logic          wave_reg;

    wire at_top    = (count_reg == period_reg);
    wire at_bottom = (count_reg <= CNT_RESTART);
    wire step      = running_reg && tick;
    wire edge_end  = step && !center && at_top;
    wire ctr_end   = step && center && down_reg && at_bottom;
    wire per_end   = edge_end || ctr_end;
    // A zero update is dropped so an update never loads a zero period
    wire upd_ok    = upd_we && (upd_val != CNT_ZERO);

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            running_reg   <= 1'b0;
            down_reg      <= 1'b0;
            stop_pend_reg <= 1'b0;
            upd_pend_reg  <= 1'b0;
            upd_val_reg   <= CNT_ZERO;
            period_reg    <= CNT_ZERO;
            count_reg     <= CNT_FIRST;
            end_reg       <= 1'b0;
            wave_reg      <= 1'b0;
        end else begin
            end_reg  <= per_end;
            wave_reg <= running_reg && (count_reg < duty);
            if (upd_ok) begin
                upd_pend_reg <= 1'b1;
                upd_val_reg  <= upd_val;
            end
            if (start && !running_reg) begin
                running_reg   <= 1'b1;
                count_reg     <= CNT_FIRST;
                period_reg    <= period_ld;
                down_reg      <= 1'b0;
                stop_pend_reg <= 1'b0;
            end else if (per_end) begin
                count_reg <= edge_end ? CNT_RESTART : count_reg;
                down_reg  <= 1'b0;
                if (upd_pend_reg && !upd_ok) begin
                    period_reg   <= upd_val_reg;
                    upd_pend_reg <= 1'b0;
                end
                // Status holds until the running period is over
                if (stop_pend_reg || stop_req) begin
                    running_reg   <= 1'b0;
                    stop_pend_reg <= 1'b0;
                end
            end else begin
                if (stop_req && running_reg) begin
                    stop_pend_reg <= 1'b1;
                end
                if (step) begin
                    if (!center || !down_reg) begin
                        if (at_top && center) begin
                            down_reg  <= 1'b1;
                            count_reg <= count_reg - CNT_ONE;
                        end else begin
                            count_reg <= count_reg + CNT_ONE;
                        end
                    end else begin
                        count_reg <= count_reg - CNT_ONE;
                    end
                end
            end
        end
    end

    assign running    = running_reg;
    assign period_end = end_reg;
    assign wave       = wave_reg;

endmodule
`default_nettype wire

// ### include/pwe_pkg.sv
package pwe_pkg;

    localparam int          NUM_CH      = 7;
    localparam int          CW          = 16;
    localparam int          PRE_W       = 10;
    localparam int          SEL_W       = 4;
    localparam logic [CW-1:0] CNT_FIRST   = 16'h0000;
    localparam logic [CW-1:0] CNT_RESTART = 16'h0001;
    localparam logic [CW-1:0] CNT_ZERO    = 16'h0000;
    localparam logic [CW-1:0] CNT_ONE     = 16'h0001;

    typedef struct packed {
        logic             enable;
        logic             halt_req;
        logic             center_align_select;
        logic [SEL_W-1:0] clk_sel;
        logic [CW-1:0]    period;
        logic [CW-1:0]    duty;
        logic             upd_we;
        logic [CW-1:0]    upd_val;
    } pwe_ch_ctrl_t;

endpackage

// ### core/pwe_top.sv
// What this block does
// - Centre-aligned enable raises channel flag immediately
// - First period from 0x0000, later from 0x0001
// - Zero written to update register is ignored
// - Enable status stays 1 until period ends
`timescale 1ns/1ps
`default_nettype none
module pwe_top
    import pwe_pkg::*;
(
    // Clock and reset
    input  wire logic                      mclk,
    input  wire logic                      rst_n,
    // Channel controls
    input  wire pwe_ch_ctrl_t [NUM_CH-1:0] ch_ctrl,
    input  wire logic                      status_read,
    // Channel status
    output logic [NUM_CH-1:0]              channel_enable_status,
    output logic [NUM_CH-1:0]              ch_flag,
    output logic [NUM_CH-1:0]              pwm_out
);

    function automatic logic tick_pick(input logic [PRE_W:0] t, input logic [SEL_W-1:0] sel);
        tick_pick = (int'(sel) <= PRE_W) ? t[sel] : 1'b0;
    endfunction

    logic              rst_s1_reg;
    logic              rst_s2_reg;
    logic [PRE_W-1:0]  pre_reg;
    logic [NUM_CH-1:0] flag_reg;
    logic [NUM_CH-1:0] flag_next;
    logic [PRE_W:0]    ticks;
    logic [NUM_CH-1:0] run_w;
    logic [NUM_CH-1:0] end_w;
    logic [NUM_CH-1:0] wave_w;
    logic [NUM_CH-1:0] ctr_start;

    // Release of reset is synchronised, assertion stays asynchronous
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rst_s1_reg <= 1'b0;
            rst_s2_reg <= 1'b0;
        end else begin
            rst_s1_reg <= 1'b1;
            rst_s2_reg <= rst_s1_reg;
        end
    end

    // Free-running prescaler, power-of-two tick taps
    always_ff @(posedge mclk or negedge rst_s2_reg) begin
        if (!rst_s2_reg) begin
            pre_reg <= '0;
        end else begin
            pre_reg <= pre_reg + {{(PRE_W-1){1'b0}}, 1'b1};
        end
    end

    assign ticks[0] = 1'b1;
    for (genvar k = 1; k <= PRE_W; k++) begin : g_tap
        assign ticks[k] = &pre_reg[k-1:0];
    end

    for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
        // Enabling a centre-aligned channel flags at once
        assign ctr_start[c] = ch_ctrl[c].enable && ch_ctrl[c].center_align_select && !run_w[c];
        pwe_channel u_ch (
            .mclk       (mclk),
            .rst_n      (rst_s2_reg),
            .tick       (tick_pick(ticks, ch_ctrl[c].clk_sel)),
            .start      (ch_ctrl[c].enable),
            .stop_req   (ch_ctrl[c].halt_req),
            .center     (ch_ctrl[c].center_align_select),
            .period_ld  (ch_ctrl[c].period),
            .duty       (ch_ctrl[c].duty),
            .upd_we     (ch_ctrl[c].upd_we),
            .upd_val    (ch_ctrl[c].upd_val),
            .running    (run_w[c]),
            .period_end (end_w[c]),
            .wave       (wave_w[c])
        );
    end

    // Set beats the read-clear in the same cycle
    assign flag_next = (status_read ? '0 : flag_reg) | end_w | ctr_start;

    always_ff @(posedge mclk or negedge rst_s2_reg) begin
        if (!rst_s2_reg) begin
            flag_reg              <= '0;
            channel_enable_status <= '0;
            pwm_out               <= '0;
        end else begin
            flag_reg              <= flag_next;
            channel_enable_status <= run_w;
            pwm_out               <= wave_w;
        end
    end

    assign ch_flag = flag_reg;

endmodule
`default_nettype wire

// ### test/pwe_top_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module pwe_top_asserts
    import pwe_pkg::*;
(
    // Watched ports
    input  wire logic                      mclk,
    input  wire logic                      rst_n,
    input  wire pwe_ch_ctrl_t [NUM_CH-1:0] ch_ctrl,
    input  wire logic                      status_read,
    input  wire logic [NUM_CH-1:0]         channel_enable_status,
    input  wire logic [NUM_CH-1:0]         ch_flag,
    input  wire logic [NUM_CH-1:0]         pwm_out
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);
    start_status_a: assert property (ch_ctrl[0].enable && !channel_enable_status[0] && !$past(ch_ctrl[0].enable)
        |-> ##2 channel_enable_status[0]) else $error("status not set after enable");
    center_flag_a: assert property (ch_ctrl[1].enable && ch_ctrl[1].center_align_select && !channel_enable_status[1]
        && !$past(ch_ctrl[1].enable) |-> ##[1:2] ch_flag[1]) else $error("no flag on centre enable");
    first_only_a: assert property (ch_ctrl[0].duty == CNT_ONE && $rose(pwm_out[0])
        |=> !pwm_out[0] [*8]) else $error("count 0 seen after a wrap");
    zero_upd_a: assert property (ch_ctrl[0].upd_we && ch_ctrl[0].upd_val == CNT_ZERO && channel_enable_status[0]
        |=> channel_enable_status[0]) else $error("zero update stopped channel");
    hold_status_a: assert property (ch_ctrl[0].halt_req && channel_enable_status[0]
        |=> channel_enable_status[0]) else $error("status dropped at disable");
    cover property (ch_ctrl[0].enable);
    cover property ($rose(ch_flag[1]));
    cover property ($fell(channel_enable_status[0]));
endmodule
bind pwe_top pwe_top_asserts chk_u (.mclk, .rst_n, .ch_ctrl, .status_read, .channel_enable_status, .ch_flag, .pwm_out);
`default_nettype wire

// ### test/pwe_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
module pwe_top_tb;
    import pwe_pkg::*;
    logic                      mclk = 0, rst_n = 0, status_read = 0, pd = 0;
    pwe_ch_ctrl_t [NUM_CH-1:0] ch_ctrl = '0;
    logic [NUM_CH-1:0]         st, fl, pw;
    int                        err_count = 0, num_checks = 0, seed = 32'h4511, p, cyc = 0;
    int                        rq[$];
    always #12.5 mclk = ~mclk;
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        pd <= pw[0];
        if (pw[0] && !pd) rq.push_back(cyc);
    end
    pwe_top dut_u (.mclk(mclk), .rst_n(rst_n), .ch_ctrl(ch_ctrl), .status_read(status_read),
                   .channel_enable_status(st), .ch_flag(fl), .pwm_out(pw));
    task automatic chk(string nm, logic [15:0] seen, logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task close_out;
        if (err_count == 0 && num_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic cy(int k);
        repeat (k) @(posedge mclk);
    endtask
    initial begin
        cy(3000);
        err_count++;
        close_out;
    end
    initial begin
        p = 4 + ($random(seed) & 3);
        for (int i = 1; i < NUM_CH; i++) begin
            ch_ctrl[i].period <= 16'h0100 | 16'($random(seed));
            ch_ctrl[i].duty <= 16'($random(seed));
        end
        // Slowest tick keeps the centre channel away from its own period end
        ch_ctrl[1].clk_sel <= 4'hA;
        ch_ctrl[1].center_align_select <= 1'b1;
        cy(8);
        rst_n <= 1'b1;
        cy(3);
        ch_ctrl[0].period <= 16'(p);
        ch_ctrl[0].duty <= CNT_ONE;
        ch_ctrl[0].enable <= 1'b1;
        ch_ctrl[1].enable <= 1'b1;
        cy(1);
        ch_ctrl[0].enable <= 1'b0;
        ch_ctrl[1].enable <= 1'b0;
        cy(3);
        chk("status", st[0], 1);
        chk("centre flag", fl[1], 1);
        status_read <= 1'b1;
        cy(1);
        status_read <= 1'b0;
        cy(2);
        chk("flag clear", fl[1], 0);
        cy(30);
        chk("first pulses", 16'(rq.size()), 1);
        ch_ctrl[0].duty <= 16'h0002;
        cy(4 * p);
        // Zero only to probe refusal; real software never writes it
        ch_ctrl[0].upd_we <= 1'b1;
        ch_ctrl[0].upd_val <= CNT_ZERO;
        cy(1);
        ch_ctrl[0].upd_we <= 1'b0;
        cy(4 * p);
        for (int i = 2; i < rq.size(); i++) chk("gap", 16'(rq[i] - rq[i-1]), 16'(p));
        wait (pw[0]);
        @(posedge mclk);
        ch_ctrl[0].halt_req <= 1'b1;
        cy(1);
        ch_ctrl[0].halt_req <= 1'b0;
        cy(1);
        chk("held status", st[0], 1);
        cy(p + 6);
        chk("late status", st[0], 0);
        close_out;
    end
endmodule
`default_nettype wire
